/* sdc_pkg.sv */
// Purpose: Shared constants for the sensor compensation chain.
// Assumes: 100 MHz aclk, 12-bit converter codes, AXI4-Lite register access.
// Notes: Byte offsets, reset values, rates and the invert, table-done, trim and clamp-high field positions live here.
package sdc_pkg;
  // ----------------------------------------------------------------
  // Clock and sample rates
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BW_SLOW_HZ = 375;   // 0.375 kHz setting.
  localparam int unsigned BW_MID_HZ = 1500;   // 1.500 kHz setting.
  localparam int unsigned BW_FAST_HZ = 3000;  // 3.000 kHz setting.
  localparam logic [1:0] BW_SLOW = 2'h0;
  localparam logic [1:0] BW_MID = 2'h1;
  // ----------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------
  localparam int TEMP_REF_C = 25;
  localparam int OFS_TERM_SCALE = 5;
  localparam int GAIN_TC_SHIFT = 16;
  localparam int OFS_TC_SHIFT = 8;
  localparam int MULT_SHIFT = 9;
  localparam logic [9:0] MULT_MIN = 10'h133;  // 0.6 with 9 fraction bits.
  localparam logic [9:0] MULT_MAX = 10'h2cd;  // 1.4 with 9 fraction bits.
  localparam int SPAN_CODES = 4096;
  localparam int PERCENT = 100;
  localparam int TBL_POINTS = 33;
  localparam int TBL_STEP = 128;
  localparam logic [12:0] TBL_MAX = 13'h1000;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_OFS_TC = 12'h004;
  localparam logic [11:0] REG_GAIN_COLD = 12'h008;
  localparam logic [11:0] REG_GAIN_WARM = 12'h00c;
  localparam logic [11:0] REG_GAIN = 12'h010;
  localparam logic [11:0] REG_CLAMP = 12'h014;
  localparam logic [11:0] REG_SHIFT = 12'h018;
  localparam logic [11:0] REG_STATUS = 12'h01c;
  localparam logic [11:0] REG_TBL_BASE = 12'h080;
  localparam logic [11:0] REG_TBL_LAST = 12'h100;
  localparam int CFG_WORDS = 7;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_IN_INV = 2;
  localparam int CTRL_OUT_INV = 3;
  localparam int CTRL_TBL_DONE = 4;
  localparam int GAIN_TRIM_LSB = 16;
  localparam int CLAMP_HIGH_LSB = 16;
  // Writable bits of each control word; the rest read as zero.
  localparam logic [31:0] CFG_MASK [0:CFG_WORDS-1] = '{32'h0000_001f, 32'h0000_ffff,
    32'h0000_ffff, 32'h0000_ffff, 32'h00ff_03ff, 32'h0fff_0fff, 32'h0000_1fff};
  // Reset values: unity multiplier, clamps at the rails.
  localparam logic [31:0] CFG_RST [0:CFG_WORDS-1] = '{32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0000, 32'h0000_0200, 32'h0fff_0000, 32'h0000_0000};
  // Register classes returned by the address decoder.
  typedef enum logic [1:0] {SDC_NONE, SDC_CFG, SDC_STAT, SDC_TBL} sdc_kind_e;
endpackage : sdc_pkg

/* sdc_chain.sv */
// Purpose: Sample, temperature-compensate, scale, linearize and clamp a sensor signal.
// Assumes: adc_code and temp_code come from logic on aclk; one AXI4-Lite slave port.
// Notes: Five-stage pipeline, one result per bandwidth tick.
// Functional notes
// RULE1 - Bandwidth setting chooses sample rate: 0.375, 1.5 or 3 kHz.
// RULE2 - Offset drift coefficient adds a term linear in temperature change.
// RULE3 - Offset compensation acts only on the already captured sample.
// RULE4 - Cold gain coefficients below 25 C, warm coefficients above.
// RULE5 - Zero coefficients make that gain correction order contribute nothing.
// RULE6 - First-order gain correction is applied before the second-order one.
// RULE7 - Compensated value is input plus gain drift term plus offset drift term.
// RULE8 - Temperature change is ambient minus 25 C, signed.
// RULE9 - Gain is applied after sampling and temperature compensation.
// RULE10 - Output is multiplier times compensated value plus trim; multiplier 0.6 to 1.4.
// RULE11 - Quiescent trim is a percentage of the output span.
// RULE12 - Signal is mapped through a 33-point, 32-segment linearization curve.
// RULE13 - Each table entry is writable alone during operation.
// RULE14 - Programmer loads all entries first, then sets the table-done flag.
// RULE15 - Entries span 0 to 4096; steps of 128 give identity transfer.
// RULE16 - Unity table plus either invert bit inverts the output.
// RULE17 - Input invert with table done linearizes the inverted input.
// RULE18 - Output is held between programmable high and low clamps.
// RULE19 - Interpolate linearly inside each segment from index and fraction.
// RULE20 - Linearization and inversion follow the trim, precede the clamps.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/10ps
module sdc_chain
#(
  parameter int unsigned DIV_SLOW = sdc_pkg::CLK_HZ / sdc_pkg::BW_SLOW_HZ,
  parameter int unsigned DIV_MID = sdc_pkg::CLK_HZ / sdc_pkg::BW_MID_HZ,
  parameter int unsigned DIV_FAST = sdc_pkg::CLK_HZ / sdc_pkg::BW_FAST_HZ
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] adc_code,
  input wire logic signed [8:0] temp_code,
  output logic [11:0] dac_code,
  output logic dac_strobe
);
  import sdc_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Address classes are needed by both the read and the write path.
  function automatic sdc_kind_e reg_kind(input logic [11:0] a);
    if (a[1:0] != 2'h0 || a > REG_TBL_LAST)
      reg_kind = SDC_NONE;
    else if (a >= REG_TBL_BASE)
      reg_kind = SDC_TBL;
    else if (a == REG_STATUS)
      reg_kind = SDC_STAT;
    else
      reg_kind = (a < REG_STATUS) ? SDC_CFG : SDC_NONE;
  endfunction : reg_kind

  // Saturate a signed intermediate to the 12-bit converter range.
  function automatic logic [11:0] sat12(input logic signed [31:0] v);
    sat12 = (v < 0) ? 12'h000 : (v > 32'sd4095) ? 12'hfff : v[11:0];
  endfunction : sat12

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] strb);
    for (int i = 0; i < 4; i++)
      old[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    strb_merge = old;
  endfunction : strb_merge

  // ----------------------------------------------------------------
  // Register file and bus state
  // ----------------------------------------------------------------
  logic [31:0] cfg_r [0:CFG_WORDS-1];
  logic [31:0] cfg_nxt [0:CFG_WORDS-1];
  logic [12:0] tbl_r [0:TBL_POINTS-1];
  logic [12:0] tbl_nxt [0:TBL_POINTS-1];
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [11:0] wa_r, wa_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt, wmerged;
  logic [5:0] tbl_widx, tbl_ridx;
  logic [2:0] cfg_widx, cfg_ridx;

  // Handshake readies are combinational; one write and one read at a time.
  assign s_axi_awready = !aw_have_r && !bvalid_r;
  assign s_axi_wready = !w_have_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // Address and data are caught in either order; the write lands once both are held.
  always_comb
  begin
    cfg_nxt = cfg_r;
    tbl_nxt = tbl_r;
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    wa_nxt = wa_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    tbl_widx = 6'((wa_r - REG_TBL_BASE) >> 2);
    cfg_widx = wa_r[4:2];
    tbl_ridx = 6'((s_axi_araddr - REG_TBL_BASE) >> 2);
    cfg_ridx = s_axi_araddr[4:2];
    wmerged = 32'h0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_have_nxt = 1'b1;
      wa_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_have_nxt = 1'b1;
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
    end
    if (aw_have_r && w_have_r)
    begin
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = 2'h0;
      case (reg_kind(wa_r))
        SDC_TBL:
        begin
          // A single entry changes; the others keep their values.  // see RULE13
          wmerged = strb_merge({19'h0, tbl_r[tbl_widx]}, wd_r, ws_r);
          tbl_nxt[tbl_widx] = (wmerged > 32'(TBL_MAX)) ? TBL_MAX : wmerged[12:0];  // see RULE15
        end
        SDC_CFG:
        begin
          wmerged = strb_merge(cfg_r[cfg_widx], wd_r, ws_r);
          cfg_nxt[cfg_widx] = wmerged & CFG_MASK[cfg_widx];
        end
        default: bresp_nxt = 2'h2;  // Status and holes answer SLVERR.
      endcase
    end
    if (bvalid_r && s_axi_bready)
      bvalid_nxt = 1'b0;
    if (rvalid_r && s_axi_rready)
      rvalid_nxt = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_nxt = 1'b1;
      rresp_nxt = 2'h0;
      case (reg_kind(s_axi_araddr))
        SDC_TBL: rdata_nxt = {19'h0, tbl_r[tbl_ridx]};
        SDC_CFG: rdata_nxt = cfg_r[cfg_ridx];
        SDC_STAT: rdata_nxt = {20'h0, dac_code};
        default:
        begin
          rdata_nxt = 32'h0;
          rresp_nxt = 2'h2;
        end
      endcase
    end
  end

  // Reset loads the identity table so the chain passes data before programming.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < CFG_WORDS; i++)
        cfg_r[i] <= CFG_RST[i];
      for (int k = 0; k < TBL_POINTS; k++)
        tbl_r[k] <= 13'(k * TBL_STEP);  // see RULE15
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      wa_r <= 12'h000;
      wd_r <= 32'h0;
      ws_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h0;
    end
    else
    begin
      cfg_r <= cfg_nxt;
      tbl_r <= tbl_nxt;
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      wa_r <= wa_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Processing pipeline
  // ----------------------------------------------------------------
  logic [31:0] div_r, div_nxt, div_lim;
  logic [4:0] vld_r, vld_nxt;
  logic [11:0] samp_r, samp_nxt, x_r, x_nxt, lin_r, lin_nxt, dac_r, dac_nxt;
  logic signed [9:0] dt_r, dt_nxt;
  logic signed [23:0] ytc_r, ytc_nxt;
  logic signed [7:0] c1, c2;
  logic signed [17:0] t1;
  logic signed [27:0] t2;
  logic signed [13:0] base, diff;
  logic signed [47:0] gain_term, off_term;
  logic signed [35:0] scaled;
  logic signed [31:0] trim_v, step;
  logic [9:0] mult;
  logic [11:0] xin, clamp_lo, clamp_hi;
  logic [12:0] e_lo, e_hi;
  logic [4:0] seg;

  always_comb
  begin
    vld_nxt = {vld_r[3:0], 1'b0};
    samp_nxt = samp_r;
    dt_nxt = dt_r;
    // Sample period follows the bandwidth code; code 3 runs at the fast rate.
    case (cfg_r[0][1:0])
      BW_SLOW: div_lim = DIV_SLOW;
      BW_MID: div_lim = DIV_MID;
      default: div_lim = DIV_FAST;
    endcase
    div_nxt = div_r + 32'h1;
    if (div_r >= div_lim - 32'h1)
    begin
      div_nxt = 32'h0;
      vld_nxt[0] = 1'b1;
      samp_nxt = adc_code;  // see RULE1
      dt_nxt = 10'(temp_code) - 10'(TEMP_REF_C);  // see RULE8
    end
    // Stage 2 works on the captured sample only, so drift terms never see raw converter data.
    c1 = (dt_r > 0) ? cfg_r[3][7:0] : cfg_r[2][7:0];  // see RULE4
    c2 = (dt_r > 0) ? cfg_r[3][15:8] : cfg_r[2][15:8];  // see RULE4
    t1 = c1 * dt_r;  // A zero coefficient yields a zero term.  // see RULE5
    t2 = 28'(c2) * 28'(dt_r * dt_r);  // see RULE5
    base = $signed({2'h0, samp_r}) - $signed({cfg_r[6][12], cfg_r[6][12:0]});  // The shift is signed.
    // First-order term is summed ahead of the second-order one.  // see RULE6
    gain_term = (48'(base) * (48'(t1) + 48'(t2))) >>> GAIN_TC_SHIFT;
    off_term = (48'($signed(cfg_r[1][7:0])) * 48'($signed({1'b0, cfg_r[1][15:8]}))
               * 48'(OFS_TERM_SCALE) * 48'(dt_r)) >>> OFS_TC_SHIFT;  // see RULE2
    ytc_nxt = vld_r[0] ? 24'($signed({1'b0, samp_r})) + 24'(gain_term) + 24'(off_term)
                       : ytc_r;  // see RULE3, RULE7
    // Stage 3: gain after compensation, multiplier held inside its legal range.
    mult = (cfg_r[4][9:0] < MULT_MIN) ? MULT_MIN : cfg_r[4][9:0];
    mult = (mult > MULT_MAX) ? MULT_MAX : mult;  // see RULE10
    scaled = (36'(ytc_r) * 36'($signed({1'b0, mult}))) >>> MULT_SHIFT;  // see RULE9
    trim_v = (32'($signed(cfg_r[4][GAIN_TRIM_LSB +: 8])) * 32'(SPAN_CODES)) / 32'(PERCENT);  // see RULE11
    x_nxt = vld_r[1] ? sat12(32'(scaled) + trim_v) : x_r;  // see RULE10
    // Stage 4: table lookup with linear interpolation inside the segment.
    xin = cfg_r[0][CTRL_IN_INV] ? ~x_r : x_r;  // see RULE16, RULE17, RULE20
    seg = xin[11:7];
    e_lo = tbl_r[seg];
    e_hi = tbl_r[6'(seg) + 6'h1];
    diff = $signed({1'b0, e_hi}) - $signed({1'b0, e_lo});
    step = (32'(diff) * 32'($signed({1'b0, xin[6:0]}))) >>> 7;  // see RULE19
    // Until the table is marked complete the curve is bypassed.  // see RULE14
    if (cfg_r[0][CTRL_TBL_DONE])
      lin_nxt = sat12(32'($signed({1'b0, e_lo})) + step);  // see RULE12, RULE17
    else
      lin_nxt = xin;
    if (cfg_r[0][CTRL_OUT_INV])
      lin_nxt = ~lin_nxt;  // see RULE16
    if (!vld_r[2])
      lin_nxt = lin_r;
    // Stage 5: clamps act last, just ahead of the converter.
    clamp_lo = cfg_r[5][11:0];
    clamp_hi = cfg_r[5][CLAMP_HIGH_LSB +: 12];
    dac_nxt = dac_r;
    if (vld_r[3])
    begin
      if (lin_r > clamp_hi)
        dac_nxt = clamp_hi;  // see RULE18
      else if (lin_r < clamp_lo)
        dac_nxt = clamp_lo;  // see RULE18
      else
        dac_nxt = lin_r;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_r <= 32'h0;
      vld_r <= 5'h0;
      samp_r <= 12'h000;
      dt_r <= 10'sh000;
      ytc_r <= 24'sh0;
      x_r <= 12'h000;
      lin_r <= 12'h000;
      dac_r <= 12'h000;
    end
    else
    begin
      div_r <= div_nxt;
      vld_r <= vld_nxt;
      samp_r <= samp_nxt;
      dt_r <= dt_nxt;
      ytc_r <= ytc_nxt;
      x_r <= x_nxt;
      lin_r <= lin_nxt;
      dac_r <= dac_nxt;
    end
  end

  assign dac_code = dac_r;
  assign dac_strobe = vld_r[4];  // One-cycle pulse with each new output word.
endmodule : sdc_chain

/* sdc_chain_assertions.sv */
// Purpose: Port-level checks of the compensation chain.
// Assumes: One aclk domain, synchronous active-low aresetn.
// Notes: Bound from tb_top; watches only the chain's ports, bench-driven inputs included.
`timescale 1ns/10ps
module sdc_chain_checker
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [11:0] dac_code,
  input wire logic dac_strobe
);
  // ----------------------------------------------------------------
  // Output stream
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Results are one tick apart, so a strobe never repeats within a few cycles.
  property p_strobe_gap;
    dac_strobe |=> !dac_strobe [*3];
  endproperty
  a_strobe_gap: assert property (p_strobe_gap) else $error("strobe too close");
  property p_code_hold;
    !dac_strobe |-> $stable(dac_code);
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("output moved without strobe");
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  property p_read_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_read_lat: assert property (p_read_lat) else $error("read answer late");
  property p_read_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data dropped");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
  property p_write_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_write_lat: assert property (p_write_lat) else $error("write answer late");
  property p_write_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write response dropped");
  property p_b_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_block: assert property (p_b_block) else $error("write taken while busy");
  // Holes above 0x100 and misaligned addresses must answer with an error and zero data.
  property p_hole_read;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr > 12'h100 || s_axi_araddr[1:0] != 2'h0)
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_hole_read: assert property (p_hole_read) else $error("hole read not refused");
  c_strobe: cover property (dac_strobe);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_hole: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : sdc_chain_checker

/* sdc_front_model.sv */
// Purpose: Converter front end and output converter around the chain.
// Assumes: Same aclk as the chain; converter words change only at edges.
// Notes: Bench sets field and temperature; the model logs each strobed result.
`timescale 1ns/10ps
module sdc_front_model
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] field_level,
  input wire logic signed [8:0] ambient_c,
  input wire logic [11:0] dac_code,
  input wire logic dac_strobe,
  output logic [11:0] adc_code,
  output logic signed [8:0] temp_code,
  output logic [11:0] seen_code,
  output int unsigned seen_count
);
  // Converter word tracks the field; the output latch keeps the last result.
  always_ff @(posedge aclk)
  begin
    adc_code <= field_level;
    temp_code <= ambient_c;
    if (!aresetn)
      seen_count <= 0;
    else if (dac_strobe)
    begin
      seen_code <= dac_code;
      seen_count <= seen_count + 1;
    end
  end
endmodule : sdc_front_model

/* tb_top.sv */
// Purpose: Self-checking bench for the compensation chain.
// Assumes: Short sample dividers so every tick fits a short run.
// Notes: Expected codes are worked by hand from the chain arithmetic.
`timescale 1ns/10ps
module tb_top;
  import sdc_pkg::*;
  localparam int D_SLOW = 24;
  localparam int D_MID = 16;
  localparam int D_FAST = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [11:0] field_level = 12'h000;
  logic signed [8:0] ambient_c = 9'sd25;
  logic awready, wready, bvalid, arready, rvalid, dac_strobe;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [11:0] adc_code, dac_code, seen_code;
  logic signed [8:0] temp_code;
  int unsigned seen_count;
  int n_mismatch = 0;
  int checked = 0;
  // ----------------------------------------------------------------
  // Design, converter model and clock
  // ----------------------------------------------------------------
  sdc_chain #(.DIV_SLOW(D_SLOW), .DIV_MID(D_MID), .DIV_FAST(D_FAST)) u_sdc_chain
  (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .adc_code(adc_code),
    .temp_code(temp_code), .dac_code(dac_code), .dac_strobe(dac_strobe)
  );
  sdc_front_model u_sdc_front_model
  (
    .aclk(aclk), .aresetn(aresetn), .field_level(field_level), .ambient_c(ambient_c),
    .dac_code(dac_code), .dac_strobe(dac_strobe), .adc_code(adc_code), .temp_code(temp_code),
    .seen_code(seen_code), .seen_count(seen_count)
  );
  initial
  begin
    forever #5 aclk = ~aclk;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Both halves offered together; each is dropped at the edge that takes it.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad;
    logic wd;
    int t;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ad = 1'b0;
    wd = 1'b0;
    t = 0;
    while (!(ad && wd) && t++ < 50)
    begin
      @(posedge aclk);
      ad = ad | awready;
      wd = wd | wready;
      if (ad)
        awvalid <= 1'b0;
      if (wd)
        wvalid <= 1'b0;
    end
    while (!bvalid && t++ < 100)
      @(posedge aclk);
    bready <= 1'b0;
    chk({31'h0, bvalid}, 32'h1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask : axw
  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    t = 0;
    @(posedge aclk);
    while (!arready && t++ < 50)
      @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (!rvalid && t++ < 100)
      @(posedge aclk);
    rready <= 1'b0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : axr
  // Wait three results so the compared one was sampled after the new inputs.
  task automatic smp(input logic [11:0] a, input int tc, input logic [11:0] e);
    int unsigned n0;
    int t;
    @(posedge aclk);
    field_level <= a;
    ambient_c <= 9'(tc);
    n0 = seen_count;
    t = 0;
    while (seen_count < n0 + 3 && t++ < 500)
      @(posedge aclk);
    // A wait that runs out counts a mismatch; the stale code is still compared.
    if (t > 500)
      n_mismatch++;
    chk({20'h0, seen_code}, {20'h0, e});
  endtask : smp
  task automatic bw_gap(input logic [1:0] bw, input int e);
    int unsigned n0;
    int t;
    axw(REG_CTRL, {30'h0, bw}, 2'h0);
    n0 = seen_count + 2;
    while (seen_count < n0)
      @(posedge aclk);
    t = 0;
    while (seen_count == n0 && t < 1000)
    begin
      @(posedge aclk);
      t++;
    end
    chk(32'(t), 32'(e));
  endtask : bw_gap
  task automatic finish_test;
    $display("Mismatches %0d of %0d checks", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    axr(REG_GAIN, 32'h200, 2'h0);
    axr(REG_CLAMP, 32'h0fff_0000, 2'h0);
    for (int k = 0; k < TBL_POINTS; k++)
      axr(REG_TBL_BASE + 12'(4 * k), 32'(TBL_STEP * k), 2'h0);
    axr(12'h104, 32'h0, 2'h2);
    axr(12'h006, 32'h0, 2'h2);
    axw(REG_STATUS, 32'h1, 2'h2);
    axw(REG_TBL_LAST, 32'h1fff, 2'h0);
    axr(REG_TBL_LAST, 32'h1000, 2'h0);
    for (int b = 0; b < 4; b++)
      bw_gap(2'(b), (b == 0) ? D_SLOW : (b == 1) ? D_MID : D_FAST);
    smp(12'h5a3, 25, 12'h5a3);
    axw(REG_CTRL, 32'h6, 2'h0);
    smp(12'h123, 25, 12'hedc);
    axw(REG_CTRL, 32'ha, 2'h0);
    smp(12'h123, 25, 12'hedc);
    axw(REG_CLAMP, 32'h0e00_0100, 2'h0);
    smp(12'h050, 25, 12'he00);
    axw(REG_CTRL, 32'h2, 2'h0);
    smp(12'h050, 25, 12'h100);
    axw(REG_CLAMP, 32'h0fff_0000, 2'h0);
    axw(REG_OFS_TC, 32'h0808, 2'h0);
    smp(12'h400, 35, 12'h40c);
    smp(12'h400, 15, 12'h3f3);
    axw(REG_OFS_TC, 32'h0, 2'h0);
    axw(REG_GAIN_WARM, 32'h0040, 2'h0);
    smp(12'h400, 35, 12'h40a);
    smp(12'h400, 15, 12'h400);
    axw(REG_GAIN_COLD, 32'h0040, 2'h0);
    smp(12'h400, 15, 12'h3f6);
    axw(REG_GAIN_WARM, 32'h0840, 2'h0);
    smp(12'h400, 35, 12'h416);
    axw(REG_SHIFT, 32'h0200, 2'h0);
    smp(12'h400, 35, 12'h40b);
    // A negative shift of -512 must enlarge the drift base, not shrink it.
    axw(REG_SHIFT, 32'h1e00, 2'h0);
    smp(12'h400, 35, 12'h421);
    axw(REG_GAIN_WARM, 32'h0, 2'h0);
    axw(REG_GAIN, 32'h2cd, 2'h0);
    smp(12'h400, 25, 12'h59a);
    axw(REG_GAIN, 32'h000a_0200, 2'h0);
    smp(12'h100, 25, 12'h299);
    axw(REG_GAIN, 32'h200, 2'h0);
    axw(REG_TBL_BASE + 12'h014, 32'h400, 2'h0);
    axw(REG_CTRL, 32'h12, 2'h0);
    smp(12'h220, 25, 12'h280);
    axw(REG_CTRL, 32'h16, 2'h0);
    smp(12'hddf, 25, 12'h280);
    axw(REG_TBL_BASE + 12'h014, 32'h300, 2'h0);
    smp(12'hddf, 25, 12'h240);
    // The status word mirrors the settled output code.
    axr(REG_STATUS, 32'h240, 2'h0);
    finish_test();
  end
  // A hang counts as a mismatch and closes the run the usual way.
  initial
  begin
    repeat (30000) @(posedge aclk);
    n_mismatch++;
    finish_test();
  end
endmodule : tb_top
bind sdc_chain sdc_chain_checker u_sdc_chain_checker
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_wready(s_axi_wready), .s_axi_wvalid(s_axi_wvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .dac_code(dac_code), .dac_strobe(dac_strobe)
);
